// >>> logic/adcraf_top.v
// result formatting, accumulation and sequencing for the successive-approximation converter
`timescale 1ns/10ps
`include "adcraf_defines.vh"

// What this block does
// - end of conversion loads high/low result bytes
// - justify field: 000 right, 100 left
// - single conversions presented as 10-bit unsigned
// - code zero to full scale, midscale 0x0200
// - unused result bits read as zero
// - accumulated sum loaded only after final conversion
// - sums of 4 to 64 samples, unsigned
// - repeat count set by accumulator config field
// - sum may shift right one to three
// - accumulation is a plain sum
// - burst off: clock divides system clock
// - burst on: clock divides low-power oscillator
// - divide ratio from converter config field
// - supports up to 300 ksps conversions
// - done flag only after full series
// - window compare only after full series
// - burst: one start runs whole series
module adcraf_top
(
    // clock and reset
    input  wire        I_CLK,
    input  wire        I_SYS_RST,
    // converter configuration
    input  wire [2:0]  I_JUSTIFY_SHIFT_SELECT,
    input  wire [2:0]  I_REPEAT_COUNT_SELECT,
    input  wire        I_BURST_ENABLE,
    input  wire [4:0]  I_CONVERTER_CLOCK_DIVIDER,
    input  wire        I_LP_OSC_TICK,
    // window limits
    input  wire [15:0] I_WINDOW_LOW,
    input  wire [15:0] I_WINDOW_HIGH,
    // conversion control and analog back end
    input  wire        I_START,
    input  wire        I_FLAG_CLEAR,
    input  wire [9:0]  I_CODE,
    // results
    output reg  [7:0]  O_RESULT_HIGH_BYTE,
    output reg  [7:0]  O_RESULT_LOW_BYTE,
    output reg         O_CONVERSION_DONE_FLAG,
    output reg         O_WINDOW_HIT,
    output wire        O_BUSY,
    output wire        O_CONVERTER_CLOCK
);
    // =====================================================
    // states
    localparam ST_IDLE = 2'h0;
    localparam ST_CONV = 2'h1;
    localparam ST_WAIT = 2'h2;

    reg  [1:0]  state_q;
    reg  [1:0]  state_d;
    reg  [4:0]  clk_cnt_q;
    reg  [4:0]  clk_cnt_d;
    reg  [6:0]  done_cnt_q;
    reg  [6:0]  done_cnt_d;
    reg  [15:0] acc_q;
    reg  [15:0] acc_d;
    reg  [2:0]  rpt_sel_q;
    reg  [2:0]  rpt_sel_d;
    reg         series_end_q;
    reg         series_end_d;
    reg  [6:0]  target;
    reg  [4:0]  sum_w;
    reg  [15:0] fmt;
    reg  [1:0]  shift_amt;
    reg         left_sel;
    wire        conv_tick;
    wire        conv_end;
    wire [15:0] acc_next;
    wire        last;
    wire [4:0]  used_w;
    wire [15:0] keep_mask;
    wire [15:0] fmt_clean;
    wire        above_low;
    wire        below_high;
    wire        in_window;

    // =====================================================
    // converter clock
    adcraf_clkdiv u_clkdiv
    (
        .i_clk          (I_CLK),
        .i_rst          (I_SYS_RST),
        .i_lp_tick      (I_LP_OSC_TICK),
        .i_burst_enable (I_BURST_ENABLE),
        .i_divider      (I_CONVERTER_CLOCK_DIVIDER),
        .o_tick         (conv_tick)
    );
    assign O_CONVERTER_CLOCK = conv_tick;
    assign O_BUSY            = (state_q != ST_IDLE);

    // =====================================================
    // repeat count decode, latched at series start
    always @*
    begin
        case (rpt_sel_q)
            `ADCRAF_RPT_4:
            begin
                target = `ADCRAF_CNT_4;
                sum_w  = `ADCRAF_SUM_W_4;
            end
            `ADCRAF_RPT_8:
            begin
                target = `ADCRAF_CNT_8;
                sum_w  = `ADCRAF_SUM_W_8;
            end
            `ADCRAF_RPT_16:
            begin
                target = `ADCRAF_CNT_16;
                sum_w  = `ADCRAF_SUM_W_16;
            end
            `ADCRAF_RPT_32:
            begin
                target = `ADCRAF_CNT_32;
                sum_w  = `ADCRAF_SUM_W_32;
            end
            `ADCRAF_RPT_64:
            begin
                target = `ADCRAF_CNT_64;
                sum_w  = `ADCRAF_SUM_W_64;
            end
            default:
            begin
                target = `ADCRAF_CNT_1;
                sum_w  = `ADCRAF_SUM_W_1;
            end
        endcase
    end

    // =====================================================
    // conversion timing
    assign conv_end = conv_tick && (clk_cnt_q == `ADCRAF_CONV_CLKS - 5'h01);
    assign acc_next = acc_q + {6'h00, I_CODE};
    assign last     = (done_cnt_q + 7'h01) >= target;

    // =====================================================
    // sequencer next state
    always @*
    begin
        state_d      = state_q;
        clk_cnt_d    = clk_cnt_q;
        done_cnt_d   = done_cnt_q;
        acc_d        = acc_q;
        rpt_sel_d    = rpt_sel_q;
        series_end_d = 1'b0;
        case (state_q)
            ST_IDLE:
            begin
                if (I_START)
                begin
                    acc_d      = 16'h0000;
                    done_cnt_d = 7'h00;
                    clk_cnt_d  = 5'h00;
                    rpt_sel_d  = I_REPEAT_COUNT_SELECT;
                    state_d    = ST_CONV;
                end
            end
            ST_CONV:
            begin
                if (conv_end)
                begin
                    clk_cnt_d  = 5'h00;
                    acc_d      = acc_next;
                    done_cnt_d = done_cnt_q + 7'h01;
                    if (last)
                    begin
                        series_end_d = 1'b1;
                        state_d      = ST_IDLE;
                    end
                    else if (!I_BURST_ENABLE)
                    begin
                        state_d = ST_WAIT;
                    end
                end
                else if (conv_tick)
                begin
                    clk_cnt_d = clk_cnt_q + 5'h01;
                end
            end
            ST_WAIT:
            begin
                if (I_START)
                begin
                    state_d = ST_CONV;
                end
            end
            default:
            begin
                state_d = ST_IDLE;
            end
        endcase
    end

    // =====================================================
    // sequencer registers
    always @(posedge I_CLK)
    begin
        if (I_SYS_RST)
        begin
            state_q      <= ST_IDLE;
            clk_cnt_q    <= 5'h00;
            done_cnt_q   <= 7'h00;
            acc_q        <= 16'h0000;
            rpt_sel_q    <= `ADCRAF_RPT_1;
            series_end_q <= 1'b0;
        end
        else
        begin
            state_q      <= state_d;
            clk_cnt_q    <= clk_cnt_d;
            done_cnt_q   <= done_cnt_d;
            acc_q        <= acc_d;
            rpt_sel_q    <= rpt_sel_d;
            series_end_q <= series_end_d;
        end
    end

    // =====================================================
    // result formatting
    always @*
    begin
        case (I_JUSTIFY_SHIFT_SELECT)
            `ADCRAF_JST_RIGHT:
            begin
                fmt       = acc_q;
                shift_amt = 2'h0;
                left_sel  = 1'b0;
            end
            `ADCRAF_JST_SHR1:
            begin
                fmt       = {1'b0, acc_q[15:1]};
                shift_amt = 2'h1;
                left_sel  = 1'b0;
            end
            `ADCRAF_JST_SHR2:
            begin
                fmt       = {2'h0, acc_q[15:2]};
                shift_amt = 2'h2;
                left_sel  = 1'b0;
            end
            `ADCRAF_JST_SHR3:
            begin
                fmt       = {3'h0, acc_q[15:3]};
                shift_amt = 2'h3;
                left_sel  = 1'b0;
            end
            `ADCRAF_JST_LEFT:
            begin
                fmt       = {acc_q[9:0], 6'h00};
                shift_amt = 2'h0;
                left_sel  = 1'b1;
            end
            default:
            begin
                fmt       = acc_q;
                shift_amt = 2'h0;
                left_sel  = 1'b0;
            end
        endcase
    end

    // =====================================================
    // zero fill of bits the layout leaves unused
    assign used_w    = sum_w - {3'h0, shift_amt};
    assign keep_mask = left_sel ? `ADCRAF_LEFT_MASK : ~(16'hFFFF << used_w);

    genvar g_bit;
    generate
        for (g_bit = 0; g_bit < `ADCRAF_ACC_W; g_bit = g_bit + 1)
        begin : g_zero_fill
            assign fmt_clean[g_bit] = fmt[g_bit] & keep_mask[g_bit];
        end
    endgenerate

    // =====================================================
    // window comparator on the presented result
    assign above_low  = (fmt_clean >= I_WINDOW_LOW);
    assign below_high = (fmt_clean <= I_WINDOW_HIGH);
    assign in_window  = above_low && below_high;

    // =====================================================
    // result registers and done flag
    always @(posedge I_CLK)
    begin
        if (I_SYS_RST)
        begin
            O_RESULT_HIGH_BYTE     <= `ADCRAF_RESULT_HI_RST;
            O_RESULT_LOW_BYTE      <= `ADCRAF_RESULT_LO_RST;
            O_CONVERSION_DONE_FLAG <= 1'b0;
            O_WINDOW_HIT           <= 1'b0;
        end
        else
        begin
            // bytes and window verdict move only at series end
            if (series_end_q)
            begin
                O_RESULT_HIGH_BYTE <= fmt_clean[15:8];
                O_RESULT_LOW_BYTE  <= fmt_clean[7:0];
                O_WINDOW_HIT       <= in_window;
            end
            // set wins over clear
            if (series_end_q)
            begin
                O_CONVERSION_DONE_FLAG <= 1'b1;
            end
            else if (I_FLAG_CLEAR)
            begin
                O_CONVERSION_DONE_FLAG <= 1'b0;
            end
        end
    end
endmodule // adcraf_top

// >>> logic/adcraf_defines.vh
// constants for the converter result accumulator and formatter
`ifndef ADCRAF_DEFINES_VH
`define ADCRAF_DEFINES_VH
// justify_shift_select encodings
`define ADCRAF_JST_RIGHT      3'h0
`define ADCRAF_JST_SHR1       3'h1
`define ADCRAF_JST_SHR2       3'h2
`define ADCRAF_JST_SHR3       3'h3
`define ADCRAF_JST_LEFT       3'h4
// repeat_count_select encodings: 1,4,8,16,32,64
`define ADCRAF_RPT_1          3'h0
`define ADCRAF_RPT_4          3'h1
`define ADCRAF_RPT_8          3'h2
`define ADCRAF_RPT_16         3'h3
`define ADCRAF_RPT_32         3'h4
`define ADCRAF_RPT_64         3'h5
// widths
`define ADCRAF_CODE_W         10
`define ADCRAF_ACC_W          16
`define ADCRAF_DIV_W          5
// conversion length in converter clocks, sample plus bits
`define ADCRAF_CONV_CLKS      5'h0D
// series lengths in conversions
`define ADCRAF_CNT_1          7'h01
`define ADCRAF_CNT_4          7'h04
`define ADCRAF_CNT_8          7'h08
`define ADCRAF_CNT_16         7'h10
`define ADCRAF_CNT_32         7'h20
`define ADCRAF_CNT_64         7'h40
// significant bits of the sum per series length
`define ADCRAF_SUM_W_1        5'h0A
`define ADCRAF_SUM_W_4        5'h0C
`define ADCRAF_SUM_W_8        5'h0D
`define ADCRAF_SUM_W_16       5'h0E
`define ADCRAF_SUM_W_32       5'h0F
`define ADCRAF_SUM_W_64       5'h10
// left layout keeps the top ten bits
`define ADCRAF_LEFT_MASK      16'hFFC0
// reset values
`define ADCRAF_RESULT_HI_RST  8'h00
`define ADCRAF_RESULT_LO_RST  8'h00
`endif

// >>> logic/adcraf_clkdiv.v
// converter clock divider with selectable source
`timescale 1ns/10ps
module adcraf_clkdiv
(
    // clock and reset
    input  wire       i_clk,
    input  wire       i_rst,
    // source select and ratio
    input  wire       i_lp_tick,
    input  wire       i_burst_enable,
    input  wire [4:0] i_divider,
    // divided tick
    output reg        o_tick
);
    reg  [4:0] cnt_q;
    wire       src_tick;

    // burst mode counts low-power oscillator ticks, else every system clock
    assign src_tick = i_burst_enable ? i_lp_tick : 1'b1;

    always @(posedge i_clk)
    begin
        if (i_rst)
        begin
            cnt_q  <= 5'h00;
            o_tick <= 1'b0;
        end
        else
        begin
            o_tick <= 1'b0;
            if (src_tick)
            begin
                if (cnt_q >= i_divider)
                begin
                    cnt_q  <= 5'h00;
                    o_tick <= 1'b1;
                end
                else
                begin
                    cnt_q <= cnt_q + 5'h01;
                end
            end
        end
    end
endmodule // adcraf_clkdiv

// >>> test/adcraf_top_sva.sv
// concurrent checks on the result accumulator ports
`timescale 1ns/10ps
module adcraf_top_sva
(
    // clock and reset
    input wire        I_CLK,
    input wire        I_SYS_RST,
    // control
    input wire        I_START,
    input wire        I_FLAG_CLEAR,
    input wire [2:0]  I_JUSTIFY_SHIFT_SELECT,
    input wire        I_BURST_ENABLE,
    input wire [4:0]  I_CONVERTER_CLOCK_DIVIDER,
    // results
    input wire [7:0]  O_RESULT_HIGH_BYTE,
    input wire [7:0]  O_RESULT_LOW_BYTE,
    input wire        O_CONVERSION_DONE_FLAG,
    input wire        O_BUSY,
    input wire        O_CONVERTER_CLOCK
);
    // ====================
    // properties
    default clocking cb @(posedge I_CLK); endclocking
    default disable iff (I_SYS_RST);
    wire [15:0] res = {O_RESULT_HIGH_BYTE, O_RESULT_LOW_BYTE};
    wire        fl  = O_CONVERSION_DONE_FLAG;
    wire [2:0]  js  = I_JUSTIFY_SHIFT_SELECT;
    wire [4:0]  dv  = I_CONVERTER_CLOCK_DIVIDER;
    property p_rst;
        @(posedge I_CLK) disable iff (1'b0) I_SYS_RST |=> res == 16'h0000 && !fl;
    endproperty
    property p_hold;  !$stable(res) |-> fl; endproperty
    property p_left;  $rose(fl) && js == 3'h4 |-> O_RESULT_LOW_BYTE[5:0] == 6'h00; endproperty
    property p_shift; $rose(fl) && js == 3'h3 |-> O_RESULT_HIGH_BYTE[7:5] == 3'h0; endproperty
    property p_done;  $rose(fl) |-> !O_BUSY; endproperty
    property p_clear;
        I_FLAG_CLEAR && !O_BUSY && $past(O_BUSY) == 1'b0 && $past(O_BUSY, 2) == 1'b0 |=> !fl;
    endproperty
    property p_take;  I_START && !O_BUSY |=> O_BUSY; endproperty
    property p_len;   $rose(O_BUSY) && dv == 5'h00 && !I_BURST_ENABLE |-> O_BUSY [*8]; endproperty
    property p_div;
        !I_BURST_ENABLE && dv == 5'h01 && $past(dv) == 5'h01 && O_CONVERTER_CLOCK |=> !O_CONVERTER_CLOCK;
    endproperty
    a_rst:   assert property (p_rst) else $error("results not cleared by reset");
    a_hold:  assert property (p_hold) else $error("result moved without done flag");
    a_left:  assert property (p_left) else $error("left layout low bits not zero");
    a_shift: assert property (p_shift) else $error("shifted sum top bits not zero");
    a_done:  assert property (p_done) else $error("done flag raised while busy");
    a_clear: assert property (p_clear) else $error("done flag not cleared");
    a_take:  assert property (p_take) else $error("start not taken when idle");
    a_len:   assert property (p_len) else $error("conversion ended too soon");
    a_div:   assert property (p_div) else $error("converter clock ratio wrong");
    c_left:  cover property ($rose(fl) && js == 3'h4);
    c_shift: cover property ($rose(fl) && js == 3'h3);
    c_burst: cover property ($rose(fl) && I_BURST_ENABLE);
endmodule // adcraf_top_sva

// >>> test/tb_adcraf_top.sv
// self-checking bench for the result accumulator block
`timescale 1ns/10ps
module tb_adcraf_top;
    reg        clk = 1'b0;
    reg        rst = 1'b1;
    reg  [2:0] jst = 3'h0;
    reg  [2:0] rpt = 3'h0;
    reg        bst = 1'b0;
    reg  [4:0] dv  = 5'h00;
    reg        lp  = 1'b0;
    reg        st  = 1'b0;
    reg        clr = 1'b0;
    reg  [9:0] cd  = 10'h000;
    reg  [15:0] wlo = 16'h0100;
    wire [7:0] hi;
    wire [7:0] lo;
    wire       fl;
    wire       hit;
    wire       busy;
    integer    num_errors = 0;
    integer    comparisons = 0;
    integer    cyc = 0;
    // ====================
    // clocks and design
    always #4 clk = ~clk;
    always @(posedge clk) lp <= #1 ~lp;
    always @(posedge clk)
    begin
        cyc = cyc + 1;
        if (cyc == 20000)
        begin
            num_errors = num_errors + 1;
            stop_test;
        end
    end
    adcraf_top uut (.I_CLK(clk), .I_SYS_RST(rst), .I_JUSTIFY_SHIFT_SELECT(jst),
        .I_REPEAT_COUNT_SELECT(rpt), .I_BURST_ENABLE(bst), .I_CONVERTER_CLOCK_DIVIDER(dv),
        .I_LP_OSC_TICK(lp), .I_WINDOW_LOW(wlo), .I_WINDOW_HIGH(16'h0FFF), .I_START(st),
        .I_FLAG_CLEAR(clr), .I_CODE(cd), .O_RESULT_HIGH_BYTE(hi), .O_RESULT_LOW_BYTE(lo),
        .O_CONVERSION_DONE_FLAG(fl), .O_WINDOW_HIT(hit), .O_BUSY(busy), .O_CONVERTER_CLOCK());
    // ====================
    // tasks
    task check(input [47:0] nm, input [15:0] exp, input [15:0] got);
    begin
        comparisons = comparisons + 1;
        if (got !== exp)
        begin
            num_errors = num_errors + 1;
            $display("ERROR %0s exp %h got %h", nm, exp, got);
        end
    end
    endtask
    task run(input [2:0] j, input [2:0] r, input b, input [4:0] d, input [9:0] c, input integer n);
        reg [15:0] e;
        integer    k;
    begin
        @(posedge clk) #1;
        jst = j;
        rpt = r;
        bst = b;
        dv = d;
        cd = c;
        clr = 1'b1;
        // burst off: one start per conversion
        for (k = 0; k < (b ? 1 : n); k = k + 1)
        begin
            if (k > 0)
                check("early", 16'h0000, {15'h0000, fl});
            st = 1'b1;
            @(posedge clk) #1;
            st = 1'b0;
            clr = 1'b0;
            if (!b)
                repeat (14 * (d + 1) + 2) @(posedge clk);
            #1;
        end
        k = 0;
        while (fl !== 1'b1 && k < 3000)
        begin
            @(posedge clk) #1;
            k = k + 1;
        end
        e = c * n;
        if (j == 3'h4)
            e = {c, 6'h00};
        else if (j != 3'h0)
            e = e >> j;
        check("flag", 16'h0001, {15'h0000, fl});
        check("result", e, {hi, lo});
        check("window", {15'h0000, (e >= wlo) && (e <= 16'h0FFF)}, {15'h0000, hit});
    end
    endtask
    task stop_test;
    begin
        $display("errors %0d comparisons %0d", num_errors, comparisons);
        if (num_errors == 0 && comparisons > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    end
    endtask
    // ====================
    // sequence
    initial
    begin
        repeat (4) @(posedge clk);
        #1 rst = 1'b0;
        check("reset", 16'h0000, {hi, lo});
        run(3'h0, 3'h0, 1'b0, 5'h00, 10'h3FF, 1);
        run(3'h4, 3'h0, 1'b0, 5'h00, 10'h200, 1);
        run(3'h0, 3'h0, 1'b1, 5'h00, 10'h200, 1);
        run(3'h0, 3'h1, 1'b1, 5'h01, 10'h3FF, 4);
        run(3'h1, 3'h1, 1'b0, 5'h00, 10'h3FF, 4);
        run(3'h2, 3'h3, 1'b1, 5'h00, 10'h3FF, 16);
        run(3'h3, 3'h5, 1'b1, 5'h00, 10'h3FF, 64);
        run(3'h0, 3'h2, 1'b0, 5'h01, 10'h100, 8);
        run(3'h0, 3'h4, 1'b1, 5'h00, 10'h1FF, 32);
        run(3'h0, 3'h0, 1'b0, 5'h00, 10'h000, 1);
        stop_test;
    end
endmodule // tb_adcraf_top
bind adcraf_top adcraf_top_sva u_sva (.I_CLK(I_CLK), .I_SYS_RST(I_SYS_RST), .I_START(I_START),
    .I_FLAG_CLEAR(I_FLAG_CLEAR), .I_JUSTIFY_SHIFT_SELECT(I_JUSTIFY_SHIFT_SELECT),
    .I_BURST_ENABLE(I_BURST_ENABLE), .I_CONVERTER_CLOCK_DIVIDER(I_CONVERTER_CLOCK_DIVIDER),
    .O_RESULT_HIGH_BYTE(O_RESULT_HIGH_BYTE), .O_RESULT_LOW_BYTE(O_RESULT_LOW_BYTE),
    .O_CONVERSION_DONE_FLAG(O_CONVERSION_DONE_FLAG), .O_BUSY(O_BUSY), .O_CONVERTER_CLOCK(O_CONVERTER_CLOCK));
